// ---- src/e2p_params.svh ----
// Purpose: constants for the energy-to-pulse converter block
// Assumes: 20 MHz core clock, 8 kHz power samples from the dsp
// Notes:   bit positions, reset values and timing figures
`ifndef E2P_PARAMS_SVH
`define E2P_PARAMS_SVH

// clock and timing figures
`define E2P_CLK_HZ        20000000
`define E2P_TICK_HZ       1000000
`define E2P_LOW_HOLD_MS   80
`define E2P_SHIFT         7

// phase_sum_config: select field of converter n at 3*n
`define E2P_TERM_LSB      0
// pulse_output_config layout
`define E2P_SEL_LSB       0
`define E2P_DIS_LSB       9
`define E2P_LATCH_LSB     12
// primary event flag and enable positions of converter 1
`define E2P_EVT_LSB       14

// reset values
`define E2P_PHASE_SUM_RST 16'h01FF
`define E2P_PULSE_CFG_RST 16'h0E88
`define E2P_DIV_RST       16'h0000
`define E2P_CYC_RST       8'h00
`define E2P_MASK_RST      32'h0000_0000

`endif

// ---- src/e2p_pkg.sv ----
// Purpose: types shared by the energy-to-pulse converter
// Assumes: nothing beyond the parameter header
// Notes:   power samples are 24-bit signed, energies 32-bit signed
package e2p_pkg;
   typedef logic signed [23:0] power_t;
   typedef logic signed [31:0] energy_t;
   // converter output state, one-hot
   typedef enum logic [1:0] {
      ST_HIGH = 2'b01,
      ST_LOW  = 2'b10
   } pulse_state_t;
   // register select of the write and read ports
   typedef enum logic [2:0] {
      R_PHASE_SUM = 3'd0,
      R_PULSE_CFG = 3'd1,
      R_DIV_ONE   = 3'd2,
      R_DIV_TWO   = 3'd3,
      R_DIV_THREE = 3'd4,
      R_LATCH_CNT = 3'd5,
      R_ENABLES   = 3'd6,
      R_FLAGS     = 3'd7
   } reg_sel_t;
   // power type codes
   typedef enum logic [2:0] {
      PT_ACTIVE   = 3'b000,
      PT_REACTIVE = 3'b001,
      PT_APPARENT = 3'b010
   } power_type_t;
endpackage

// ---- src/energy_to_pulse_converter.sv ----
// Purpose: three energy-to-frequency converters with led pulse pins
// Assumes: samples index type*3+phase (a,b,c); same clock as dsp
// Notes:   registers reached through a select/strobe port
//
// Contract
// - pin three forced high while the capture port is enabled.
// - phase-sum fields at bits 2..0, 5..3, 8..6 of phase_sum_config.
// - field bits 0,1,2 include phases a,b,c when set.
// - all-zero phase-sum field sums nothing and gives no pulses.
// - power-type fields at bits 2..0, 5..3, 8..6 of pulse_output_config.
// - type 000 active, 001 reactive, 010 apparent, rest reserved.
// - phase-sum bits reset to one; types reset 000, 001, 010.
// - selected samples shifted left 7, accumulated at 1 MHz.
// - threshold reached gives internal pulse, threshold subtracted.
// - energy sign at crossing becomes sign of the sum.
// - second stage divides by converter's own 16-bit divider.
// - divider zero behaves as divider one.
// - divider one gives a 1 us low pulse; software avoids it.
// - pulse period above 160 ms gives exactly 80 ms low.
// - faster: even divider 50% duty, odd (1+1/den)*50%.
// - pulse outputs are active low, idle high.
// - disable bits 11,10,9 hold pins 3,2,1 high; reset one.
// - enables 16,15,14 set flags and drive event line on falls.
// - latch copies three phase energies of type, then clears them.
// - 8-bit latch count sets falls between two latch events.
// - latch enables 14,13,12 reset zero; work with pin disabled.
// - writing one clears flag and releases the event line.
// - first-stage accumulator is 55 bits wide.
`timescale 1ns/1ns
`include "e2p_params.svh"

module energy_to_pulse_converter #(
   parameter int LOW_HOLD_CYCLES =
      `E2P_LOW_HOLD_MS * (`E2P_CLK_HZ / 1000)
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic             sample_valid,
   input  wire e2p_pkg::power_t  power_sample [9],
   input  wire logic [47:0]      active_energy_threshold,
   input  wire logic [47:0]      reactive_energy_threshold,
   input  wire logic [47:0]      apparent_energy_threshold,
   input  wire logic             capture_port_enable,
   input  wire logic             reg_wr_en,
   input  wire e2p_pkg::reg_sel_t reg_wr_sel,
   input  wire logic [31:0]      reg_wr_data,
   input  wire e2p_pkg::reg_sel_t reg_rd_sel,
   output logic [31:0]           reg_rd_data,
   output logic                  pulse_out_one,
   output logic                  pulse_out_two,
   output logic                  pulse_out_three,
   output logic                  primary_event_line_b,
   output logic [2:0]            sum_sign,
   output e2p_pkg::energy_t      phase_energy [9]
);
   import e2p_pkg::*;

   // every check below runs on the core clock, quiet while in reset
   default clocking core_cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   localparam int TICK_DIV = `E2P_CLK_HZ / `E2P_TICK_HZ;

   ////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [16:0] eff_den(input logic [15:0] den);
      eff_den = (den == 16'h0000) ? 17'd1 : {1'b0, den};
   endfunction

   // selected phase sum for one converter, 26-bit signed
   function automatic logic signed [25:0] phase_sum(
      input logic [2:0] term, input logic [2:0] ptype,
      input power_t s [9]);
      logic signed [25:0] acc;
      int base;
      acc = '0;
      base = 0;
      case (ptype)
         PT_ACTIVE:   base = 0;
         PT_REACTIVE: base = 3;
         PT_APPARENT: base = 6;
         default:     base = -1; // reserved code adds nothing
      endcase
      for (int p = 0; p < 3; p++) begin
         if (base >= 0 && term[p]) begin
            acc = acc + 26'(s[base + p]);
         end
      end
      return acc;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0]        phase_sum_config;
   logic [15:0]        pulse_output_config;
   logic [15:0]        divider [3];
   logic [7:0]         latch_pulse_count;
   logic [31:0]        primary_event_enables;
   logic [31:0]        primary_event_flags;
   logic [2:0]         fall;

   // configuration writes
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         phase_sum_config      <= `E2P_PHASE_SUM_RST;
         pulse_output_config   <= `E2P_PULSE_CFG_RST;
         divider               <= '{default: `E2P_DIV_RST};
         latch_pulse_count     <= `E2P_CYC_RST;
         primary_event_enables <= `E2P_MASK_RST;
      end else if (reg_wr_en) begin
         case (reg_wr_sel)
            R_PHASE_SUM: phase_sum_config <= reg_wr_data[15:0];
            R_PULSE_CFG: pulse_output_config <= reg_wr_data[15:0];
            R_DIV_ONE:   divider[0] <= reg_wr_data[15:0];
            R_DIV_TWO:   divider[1] <= reg_wr_data[15:0];
            R_DIV_THREE: divider[2] <= reg_wr_data[15:0];
            R_LATCH_CNT: latch_pulse_count <= reg_wr_data[7:0];
            R_ENABLES:   primary_event_enables <= reg_wr_data;
            default:     ;
         endcase
      end
   end

   // flags: set wins over a same-cycle write-one clear
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         primary_event_flags <= '0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (fall[i] && primary_event_enables[`E2P_EVT_LSB + i]) begin
               primary_event_flags[`E2P_EVT_LSB + i] <= 1'b1;
            end else if (reg_wr_en && reg_wr_sel == R_FLAGS &&
                         reg_wr_data[`E2P_EVT_LSB + i]) begin
               primary_event_flags[`E2P_EVT_LSB + i] <= 1'b0;
            end
         end
      end
   end

   // event line follows any raised flag one cycle later
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         primary_event_line_b <= 1'b1;
      end else begin
         primary_event_line_b <= ~|primary_event_flags;
      end
   end

   // registered read port
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         reg_rd_data <= '0;
      end else begin
         case (reg_rd_sel)
            R_PHASE_SUM: reg_rd_data <= {16'h0000, phase_sum_config};
            R_PULSE_CFG: reg_rd_data <= {16'h0000, pulse_output_config};
            R_DIV_ONE:   reg_rd_data <= {16'h0000, divider[0]};
            R_DIV_TWO:   reg_rd_data <= {16'h0000, divider[1]};
            R_DIV_THREE: reg_rd_data <= {16'h0000, divider[2]};
            R_LATCH_CNT: reg_rd_data <= {24'h00_0000, latch_pulse_count};
            R_ENABLES:   reg_rd_data <= primary_event_enables;
            default:     reg_rd_data <= primary_event_flags;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // 1 MHz accumulation tick and held samples
   logic [4:0]         tick_cnt;
   logic               tick;
   power_t             held [9];

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else begin
         tick     <= (tick_cnt == 5'(TICK_DIV - 1));
         tick_cnt <= (tick_cnt == 5'(TICK_DIV - 1)) ? 5'd0
                                                    : tick_cnt + 5'd1;
      end
   end

   // the 8 kHz sample is held and re-added on every tick
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         held <= '{default: '0};
      end else if (sample_valid) begin
         held <= power_sample;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // first stage: 55-bit accumulator against threshold << 7
   logic signed [54:0] stage1 [3];
   logic [2:0]         ipulse;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         stage1   <= '{default: '0};
         ipulse   <= '0;
         sum_sign <= '0;
      end else begin
         ipulse <= '0;
         for (int c = 0; c < 3; c++) begin
            logic [2:0]         term;
            logic [2:0]         ptype;
            logic [47:0]        thr;
            logic signed [55:0] nxt;
            logic signed [55:0] th7;
            term  = phase_sum_config[`E2P_TERM_LSB + 3*c +: 3];
            ptype = pulse_output_config[`E2P_SEL_LSB + 3*c +: 3];
            case (ptype)
               PT_REACTIVE: thr = reactive_energy_threshold;
               PT_APPARENT: thr = apparent_energy_threshold;
               default:     thr = active_energy_threshold;
            endcase
            th7 = {1'b0, thr, 7'h00};
            nxt = 56'(stage1[c]);
            if (tick) begin
               nxt = nxt + 56'(phase_sum(term, ptype, held)
                               <<< `E2P_SHIFT);
            end
            if (tick && th7 != '0 && nxt >= th7) begin
               nxt         = nxt - th7;
               ipulse[c]  <= 1'b1;
               sum_sign[c] <= 1'b0;
            end else if (tick && th7 != '0 && -nxt >= th7) begin
               nxt         = nxt + th7;
               ipulse[c]  <= 1'b1;
               sum_sign[c] <= 1'b1;
            end
            stage1[c] <= nxt[54:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // second stage: divider and pulse shaping
   pulse_state_t       pstate [3];
   logic [16:0]        div_cnt [3];
   logic [16:0]        low_cnt [3];
   logic [20:0]        hold_cnt [3];

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pstate   <= '{default: ST_HIGH};
         div_cnt  <= '{default: '0};
         low_cnt  <= '{default: '0};
         hold_cnt <= '{default: '0};
         fall     <= '0;
      end else begin
         fall <= '0;
         for (int c = 0; c < 3; c++) begin
            logic [16:0] den;
            den = eff_den(divider[c]);
            if (ipulse[c]) begin
               if (div_cnt[c] + 17'd1 >= den) begin
                  div_cnt[c]  <= '0;
                  low_cnt[c]  <= '0;
                  hold_cnt[c] <= '0;
                  pstate[c]   <= ST_LOW;
                  fall[c]     <= (pstate[c] == ST_HIGH);
               end else begin
                  div_cnt[c] <= div_cnt[c] + 17'd1;
               end
            end
            case (pstate[c])
               ST_LOW: begin
                  hold_cnt[c] <= hold_cnt[c] + 21'd1;
                  if (ipulse[c] && div_cnt[c] + 17'd1 < den) begin
                     low_cnt[c] <= low_cnt[c] + 17'd1;
                  end
                  // divider one: low for one full tick period, 1 us
                  if (den == 17'd1 &&
                      hold_cnt[c] + 21'd1 >= 21'(TICK_DIV)) begin
                     pstate[c] <= ST_HIGH;
                  end else if (den > 17'd1 && ipulse[c] &&
                      div_cnt[c] + 17'd1 < den &&
                      low_cnt[c] + 17'd1 >= (den + 17'd1) >> 1) begin
                     pstate[c] <= ST_HIGH;
                  end else if (hold_cnt[c] + 21'd1 >=
                               21'(LOW_HOLD_CYCLES)) begin
                     pstate[c] <= ST_HIGH;
                  end
               end
               ST_HIGH: ;
               default: pstate[c] <= ST_HIGH;
            endcase
         end
      end
   end

   // pins: active low, disable and capture-port override
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pulse_out_one   <= 1'b1;
         pulse_out_two   <= 1'b1;
         pulse_out_three <= 1'b1;
      end else begin
         pulse_out_one   <= !(pstate[0] == ST_LOW &&
                              !pulse_output_config[`E2P_DIS_LSB]);
         pulse_out_two   <= !(pstate[1] == ST_LOW &&
                              !pulse_output_config[`E2P_DIS_LSB + 1]);
         pulse_out_three <= !(pstate[2] == ST_LOW && !capture_port_enable &&
                              !pulse_output_config[`E2P_DIS_LSB + 2]);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // phase energies and latch on every n-th fall
   energy_t            phase_acc [9];
   logic [7:0]         latch_cnt [3];

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         phase_acc    <= '{default: '0};
         phase_energy <= '{default: '0};
         latch_cnt    <= '{default: '0};
      end else begin
         for (int k = 0; k < 9; k++) begin
            if (sample_valid) begin
               phase_acc[k] <= phase_acc[k] + 32'(power_sample[k]);
            end
         end
         for (int c = 0; c < 3; c++) begin
            logic [2:0] ptype;
            logic [7:0] lim;
            ptype = pulse_output_config[`E2P_SEL_LSB + 3*c +: 3];
            lim   = (latch_pulse_count == 8'h00) ? 8'h01
                                                 : latch_pulse_count;
            if (fall[c] && pulse_output_config[`E2P_LATCH_LSB + c]) begin
               if (latch_cnt[c] + 8'h01 >= lim) begin
                  latch_cnt[c] <= '0;
                  if (ptype <= PT_APPARENT) begin
                     for (int p = 0; p < 3; p++) begin
                        // all three phases, whatever the phase sum
                        phase_energy[3*ptype + p] <=
                           phase_acc[3*ptype + p];
                        phase_acc[3*ptype + p] <= sample_valid ?
                           32'(power_sample[3*ptype + p]) : '0;
                     end
                  end
               end else begin
                  latch_cnt[c] <= latch_cnt[c] + 8'h01;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   a_flag_sets: assert property (
      fall[0] && primary_event_enables[14] |=> primary_event_flags[14])
      else $error("converter one flag not set on fall");
   a_line_follows: assert property (
      primary_event_flags != '0 |=> !primary_event_line_b)
      else $error("event line not low with flag raised");
   a_flag_clears: assert property (
      reg_wr_en && reg_wr_sel == R_FLAGS && reg_wr_data[14] && !fall[0]
      |=> !primary_event_flags[14])
      else $error("write one did not clear flag");
   a_pin_disabled: assert property (
      pulse_output_config[`E2P_DIS_LSB + 1] |=> pulse_out_two)
      else $error("disabled pin went low");
   a_capture_owns: assert property (
      capture_port_enable |=> pulse_out_three)
      else $error("pin three driven while capture port on");
   a_no_terms: assert property (
      phase_sum_config[2:0] == 3'b000 && stage1[0] == '0
      |=> ipulse[0] == 1'b0)
      else $error("pulse with empty phase sum");
   a_low_on_fall: assert property (
      fall[0] && !pulse_output_config[`E2P_DIS_LSB] |=> !pulse_out_one)
      else $error("pin one not low after fall");
   a_low_bounded: assert property (
      pstate[0] == ST_LOW |-> hold_cnt[0] < 21'(LOW_HOLD_CYCLES))
      else $error("low time above hold limit");
   a_fall_needs_pulse: assert property (
      fall[2] |-> $past(ipulse[2]))
      else $error("fall without internal pulse");
   c_fall_one:  cover property (@(posedge core_clk) fall[0]);
   c_latch_two: cover property (@(posedge core_clk)
      fall[1] && pulse_output_config[`E2P_LATCH_LSB + 1]);
   c_neg_sum:   cover property (@(posedge core_clk)
      ipulse[2] ##1 sum_sign[2]);
endmodule

// ---- tb/led_counter_model.sv ----
// Purpose: led pulse counter standing in for the calibration gear
// Assumes: one instance per pulse pin, sampled on core_clk
// Notes:   reports fall count and the last complete low width
`timescale 1ns/1ns

module led_counter_model (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic led_b,
   output int        falls,
   output int        low_len
);
   int   run;
   logic led_q;

   // width is only known once the led goes dark again
   always_ff @(posedge core_clk) begin
      led_q <= led_b;
      if (!rst_b) begin
         falls   <= 0;
         run     <= 0;
         low_len <= 0;
      end else if (!led_b) begin
         run <= run + 1;
         if (led_q)
            falls <= falls + 1;
      end else begin
         if (!led_q)
            low_len <= run;
         run <= 0;
      end
   end
endmodule

// ---- tb/tb_top.sv ----
// Purpose: register-level test of the energy-to-pulse converter
// Assumes: low hold scaled to 2000 cycles; samples renewed per 100
// Notes:   pulse widths come from one led model per pin
`timescale 1ns/1ns

module tb_top;
   import e2p_pkg::*;

   localparam int HOLD = 2000;
   logic        core_clk;
   logic        rst_b;
   logic        sample_valid;
   power_t      samp [9];
   logic        capture_port_enable;
   logic        reg_wr_en;
   reg_sel_t    reg_wr_sel;
   logic [31:0] reg_wr_data;
   reg_sel_t    reg_rd_sel;
   logic [31:0] reg_rd_data;
   logic [2:0]  pins;
   logic        line_b;
   logic [2:0]  sum_sign;
   energy_t     energy [9];
   int          falls [3];
   int          low_len [3];
   int          fail_count;
   int          cmp_count;
   logic [31:0] rv;
   int          w;
   energy_t     e1;
   int          dens [6] = '{0, 1, 3, 4, 5, 300};
   logic [31:0] rst_vals [8] = '{0: 32'h0000_01FF, 1: 32'h0000_0E88,
                                 default: 32'h0};

`define CHK(name, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("CHECK FAILED %s exp %0h got %0h", name, exp, got); \
      end \
   end

   energy_to_pulse_converter #(.LOW_HOLD_CYCLES(HOLD))
      i_energy_to_pulse_converter (
      .core_clk                  (core_clk),
      .rst_b                     (rst_b),
      .sample_valid              (sample_valid),
      .power_sample              (samp),
      .active_energy_threshold   (48'h0000_0000_012C),
      .reactive_energy_threshold (48'h0000_0000_0258),
      .apparent_energy_threshold (48'h0000_0000_0384),
      .capture_port_enable       (capture_port_enable),
      .reg_wr_en                 (reg_wr_en),
      .reg_wr_sel                (reg_wr_sel),
      .reg_wr_data               (reg_wr_data),
      .reg_rd_sel                (reg_rd_sel),
      .reg_rd_data               (reg_rd_data),
      .pulse_out_one             (pins[0]),
      .pulse_out_two             (pins[1]),
      .pulse_out_three           (pins[2]),
      .primary_event_line_b      (line_b),
      .sum_sign                  (sum_sign),
      .phase_energy              (energy)
   );

   for (genvar g = 0; g < 3; g++) begin : led
      led_counter_model i_led_counter_model (
         .core_clk (core_clk),
         .rst_b    (rst_b),
         .led_b    (pins[g]),
         .falls    (falls[g]),
         .low_len  (low_len[g])
      );
   end

   ////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic stuck(input string what);
      fail_count++;
      $display("CHECK FAILED %s exp done got timeout", what);
      print_verdict();
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask

   // idle cycle after each strobe so it is never set twice at once
   task automatic wr(input reg_sel_t s, input logic [31:0] d);
      reg_wr_sel  = s;
      reg_wr_data = d;
      reg_wr_en   = 1'b1;
      tick(1);
      reg_wr_en   = 1'b0;
      tick(1);
   endtask

   task automatic rd(input reg_sel_t s, output logic [31:0] d);
      reg_rd_sel = s;
      tick(2);
      d = reg_rd_data;
   endtask

   // returns with the pin back high after n falls
   task automatic wait_falls(input int k, input int n);
      int f0;
      int c;
      f0 = falls[k];
      c  = 0;
      while (falls[k] < f0 + n || pins[k] !== 1'b1) begin
         tick(1);
         c++;
         if (c > 30000)
            stuck("pulse pin");
      end
      tick(1);
   endtask

   task automatic meas(input int k, input int exp);
      wait_falls(k, 2);
      `CHK("low width", exp, low_len[k])
   endtask

   task automatic quiet(input int k);
      int f0;
      tick(20);
      f0 = falls[k];
      tick(400);
      `CHK("no falls", 0, falls[k] - f0)
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // dsp stand-in, faster than 8 kHz to keep the run short
   initial begin
      sample_valid = 1'b0;
      forever begin
         tick(99);
         sample_valid = 1'b1;
         tick(1);
         sample_valid = 1'b0;
      end
   end

   initial begin
      int c;
      fail_count          = 0;
      cmp_count           = 0;
      rst_b               = 1'b0;
      capture_port_enable = 1'b0;
      reg_wr_en           = 1'b0;
      reg_wr_sel          = R_PHASE_SUM;
      reg_wr_data         = 32'h0;
      reg_rd_sel          = R_PHASE_SUM;
      // phase a 100, b 200, c 0 active; all others 100
      foreach (samp[i])
         samp[i] = 24'h00_0064;
      samp[1] = 24'h00_00C8;
      samp[2] = 24'h00_0000;
      tick(3);
      rst_b = 1'b1;
      foreach (rst_vals[i]) begin
         rd(reg_sel_t'(i), rv);
         `CHK("reset reg", rst_vals[i], rv)
      end
      `CHK("idle pins", 3'b111, pins)
      quiet(0);
      // type k gives one internal pulse per k+1 ticks
      wr(R_DIV_ONE, 32'h0000_0002);
      for (int t = 0; t < 3; t++) begin
         wr(R_PULSE_CFG, 32'h0000_0C88 | t);
         meas(0, 20 * (t + 1));
      end
      wr(R_PULSE_CFG, 32'h0000_0C8B);
      quiet(0);
      // reactive feed: period 40 cycles per internal pulse
      wr(R_PULSE_CFG, 32'h0000_0C89);
      foreach (dens[i]) begin
         wr(R_DIV_ONE, dens[i]);
         w = (dens[i] < 2) ? 20 : 40 * ((dens[i] + 1) / 2);
         meas(0, (w > HOLD) ? HOLD : w);
      end
      wr(R_DIV_ONE, 32'h0000_0002);
      wr(R_PULSE_CFG, 32'h0000_0C88);
      wr(R_PHASE_SUM, 32'h0000_01F9);
      meas(0, 60);
      wr(R_PHASE_SUM, 32'h0000_01FC);
      quiet(0);
      wr(R_PHASE_SUM, 32'h0000_01F8);
      quiet(0);
      wr(R_PHASE_SUM, 32'h0000_01FF);
      wr(R_PULSE_CFG, 32'h0000_0088);
      wr(R_DIV_TWO, 32'h0000_0002);
      wr(R_DIV_THREE, 32'h0000_0002);
      meas(1, 40);
      meas(2, 60);
      capture_port_enable = 1'b1;
      quiet(2);
      capture_port_enable = 1'b0;
      samp[0] = -samp[0];
      samp[1] = -samp[1];
      tick(120);
      meas(0, 20);
      `CHK("sign neg", 1'b1, sum_sign[0])
      samp[0] = -samp[0];
      samp[1] = -samp[1];
      tick(120);
      meas(0, 20);
      `CHK("sign pos", 1'b0, sum_sign[0])
      // flags still raised with every pin held off
      wr(R_PULSE_CFG, 32'h0000_0E88);
      wr(R_ENABLES, 32'h0000_4000);
      c = 0;
      while (line_b !== 1'b0) begin
         tick(1);
         c++;
         if (c > 500)
            stuck("event line");
      end
      rd(R_FLAGS, rv);
      `CHK("flags", 32'h0000_4000, rv)
      `CHK("pins off", 3'b111, pins)
      wr(R_PHASE_SUM, 32'h0000_01F8);
      tick(50);
      wr(R_FLAGS, 32'h0000_4000);
      tick(3);
      `CHK("line", 1'b1, line_b)
      rd(R_FLAGS, rv);
      `CHK("flags clr", 32'h0, rv)
      // latch windows of one and two periods of 800 cycles
      wr(R_PHASE_SUM, 32'h0000_01FF);
      wr(R_DIV_ONE, 32'h0000_0028);
      `CHK("no latch", 32'h0, energy[1])
      wr(R_PULSE_CFG, 32'h0000_1C88);
      wait_falls(0, 1);
      wr(R_LATCH_CNT, 32'h0000_0001);
      wait_falls(0, 5);
      e1 = energy[1];
      `CHK("latched", 1'b1, e1 > 0)
      `CHK("other type", 32'h0, energy[4])
      wait_falls(0, 1);
      wr(R_LATCH_CNT, 32'h0000_0002);
      wait_falls(0, 5);
      `CHK("longer window", 1'b1, energy[1] > e1)
      rst_b = 1'b0;
      tick(1);
      `CHK("rst pins", 3'b111, pins)
      `CHK("rst energy", 32'h0, energy[1])
      `CHK("rst sign", 3'b000, sum_sign)
      tick(2);
      rst_b = 1'b1;
      // empty sum while the first-stage sum is still clear
      wr(R_PHASE_SUM, 32'h0000_01F8);
      rd(R_PULSE_CFG, rv);
      `CHK("rst cfg", 32'h0000_0E88, rv)
      print_verdict();
   end
endmodule
